/* File: rtl/gcfc_core.v */
`timescale 1ns/1ns
`include "gcfc_defs.vh"
module gcfc_core (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // register access
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata,
    // analog side
    input wire [8:0] dieTemp,
    input wire [2:0] senseLevel,
    input wire calDone,
    // serial link pin
    input wire linkPin,
    // status open-drain pin
    output wire statusOut,
    output wire statusOe,
    // counter clear pulses, bit order as clear register
    output reg [4:0] counterClear,
    // power control
    output reg forceReset,
    output reg sleeping,
    output reg calibrating
);
    localparam ST_IDLE = 6'h01;
    localparam ST_RUN = 6'h02;
    localparam ST_WAIT = 6'h04;
    localparam ST_CAL = 6'h08;
    localparam ST_SLEEP = 6'h10;
    localparam ST_DONE = 6'h20;

    reg [7:0] flashMem [0:127];
    reg [7:0] ramMem [0:31];
    reg [7:0] clear_reg;
    reg [7:0] cmd_reg;
    reg [7:0] progData_reg;
    reg [7:0] progAddr_reg;
    reg [2:0] wake_reg;
    reg [8:0] temp_reg;
    reg [5:0] state_reg;
    reg [5:0] state_next;
    reg [6:0] idx_reg;
    reg [6:0] last_reg;
    reg [7:0] calCnt_reg;
    reg porSeen_reg;
    wire linkLevel;
    wire linkToggle;
    wire senseOk;

    gcfc_sync linkSync (
        .clock(clock),
        .rst_n(rst_n),
        .pinIn(linkPin),
        .pinLevel(linkLevel),
        .pinToggle(linkToggle)
    );

    function isCommand;
        input [7:0] code;
        begin
            case (code)
                `GCFC_CMD_PROGRAM, `GCFC_CMD_ERASE0, `GCFC_CMD_ERASE1,
                `GCFC_CMD_ERASE2, `GCFC_CMD_ERASE_OFS, `GCFC_CMD_RAM2FL,
                `GCFC_CMD_FL2RAM, `GCFC_CMD_SLEEP, `GCFC_CMD_CALSLEEP: isCommand = 1'b1;
                default: isCommand = 1'b0;
            endcase
        end
    endfunction

    function [6:0] firstIdx;
        input [7:0] code;
        begin
            case (code)
                `GCFC_CMD_PROGRAM: firstIdx = progAddr_reg[6:0];
                `GCFC_CMD_ERASE1: firstIdx = 7'h20;
                `GCFC_CMD_ERASE2: firstIdx = 7'h40;
                `GCFC_CMD_ERASE_OFS: firstIdx = `GCFC_FLASH_OFS_BASE;
                default: firstIdx = 7'h00;
            endcase
        end
    endfunction

    function [6:0] lastIdx;
        input [7:0] code;
        begin
            case (code)
                `GCFC_CMD_PROGRAM: lastIdx = progAddr_reg[6:0];
                `GCFC_CMD_ERASE1: lastIdx = 7'h3f;
                `GCFC_CMD_ERASE2: lastIdx = 7'h5f;
                `GCFC_CMD_ERASE_OFS: lastIdx = `GCFC_FLASH_OFS_BASE + 7'h02;
                default: lastIdx = {2'b00, `GCFC_LAST_PAGE_OFS};
            endcase
        end
    endfunction

    // sense below threshold; zero threshold always allows sleep
    assign senseOk = (wake_reg == 3'h0) || (senseLevel < wake_reg);

    // open drain: drive low while bit is 0
    assign statusOut = 1'b0;
    assign statusOe = ~clear_reg[`GCFC_BIT_STAT];

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (regWrite && regAddr == `GCFC_ADDR_FLASH_CMD && isCommand(regWdata)) begin
                    if (regWdata == `GCFC_CMD_SLEEP || regWdata == `GCFC_CMD_CALSLEEP) begin
                        state_next = ST_WAIT;
                    end else begin
                        state_next = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (idx_reg == last_reg) begin
                    state_next = ST_DONE;
                end
            end
            ST_WAIT: begin
                if (linkToggle) begin
                    state_next = ST_DONE;
                end else if (senseOk) begin
                    if (cmd_reg == `GCFC_CMD_CALSLEEP) begin
                        state_next = ST_CAL;
                    end else begin
                        state_next = ST_SLEEP;
                    end
                end
            end
            ST_CAL: begin
                if (linkToggle) begin
                    state_next = ST_DONE;
                end else if (calDone || calCnt_reg == `GCFC_CAL_CYCLES) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (linkToggle) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            idx_reg <= 7'h00;
            last_reg <= 7'h00;
            calCnt_reg <= 8'h00;
            cmd_reg <= 8'h00;
            sleeping <= 1'b0;
            calibrating <= 1'b0;
        end else begin
            state_reg <= state_next;
            sleeping <= (state_next == ST_SLEEP);
            calibrating <= (state_next == ST_CAL);
            if (state_reg == ST_CAL) begin
                calCnt_reg <= calCnt_reg + 8'h01;
            end else begin
                calCnt_reg <= 8'h00;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (state_next != ST_IDLE) begin
                        cmd_reg <= regWdata;
                        idx_reg <= firstIdx(regWdata);
                        last_reg <= lastIdx(regWdata);
                    end
                end
                ST_RUN: begin
                    idx_reg <= idx_reg + 7'h01;
                end
                ST_DONE: begin
                    cmd_reg <= 8'h00;
                end
                default: begin
                    idx_reg <= idx_reg;
                end
            endcase
        end
    end

    // memory moves, one byte per cycle; unknown codes never reach here
    always @(posedge clock) begin
        if (state_reg == ST_RUN) begin
            case (cmd_reg)
                `GCFC_CMD_PROGRAM: flashMem[idx_reg] <= flashMem[idx_reg] & progData_reg;
                `GCFC_CMD_ERASE0, `GCFC_CMD_ERASE1, `GCFC_CMD_ERASE2: flashMem[idx_reg] <= `GCFC_ERASED;
                `GCFC_CMD_ERASE_OFS: flashMem[idx_reg] <= `GCFC_ERASED;
                `GCFC_CMD_RAM2FL: flashMem[idx_reg] <= ramMem[idx_reg[4:0]];
                default: flashMem[idx_reg] <= flashMem[idx_reg];
            endcase
        end
    end

    always @(posedge clock) begin
        if (state_reg == ST_RUN && cmd_reg == `GCFC_CMD_FL2RAM) begin
            ramMem[idx_reg[4:0]] <= flashMem[idx_reg];
        end
    end

    // clear register, program registers, mode and temperature
    always @(posedge clock) begin
        if (!rst_n) begin
            clear_reg <= `GCFC_CLEAR_RESET;
            progData_reg <= 8'h00;
            progAddr_reg <= 8'h00;
            wake_reg <= `GCFC_WAKE_RESET;
            temp_reg <= 9'h000;
            counterClear <= 5'h00;
            forceReset <= 1'b0;
            porSeen_reg <= 1'b0;
        end else begin
            porSeen_reg <= 1'b1;
            temp_reg <= dieTemp;
            counterClear <= 5'h00;
            forceReset <= 1'b0;
            clear_reg[4:0] <= 5'h00;
            if (regWrite) begin
                case (regAddr)
                    `GCFC_ADDR_CLEAR: begin
                        counterClear <= regWdata[4:0];
                        clear_reg[`GCFC_BIT_STAT] <= regWdata[`GCFC_BIT_STAT];
                        clear_reg[`GCFC_BIT_POR] <= regWdata[`GCFC_BIT_POR];
                        clear_reg[`GCFC_BIT_RESERVED_TOP_BIT] <= regWdata[`GCFC_BIT_RESERVED_TOP_BIT];
                        forceReset <= regWdata[`GCFC_BIT_RESERVED_TOP_BIT] & ~clear_reg[`GCFC_BIT_RESERVED_TOP_BIT];
                    end
                    `GCFC_ADDR_MODE: wake_reg <= regWdata[3:1];
                    `GCFC_ADDR_PROG_DATA: progData_reg <= regWdata;
                    `GCFC_ADDR_PROG_ADDR: progAddr_reg <= regWdata;
                    default: progData_reg <= progData_reg;
                endcase
            end
        end
    end

    // read mux
    always @(posedge clock) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                `GCFC_ADDR_TEMP_LOW: regRdata <= temp_reg[7:0];
                `GCFC_ADDR_TEMP_HIGH: regRdata <= {7'h00, temp_reg[8]};
                `GCFC_ADDR_FLASH_CMD: regRdata <= cmd_reg;
                `GCFC_ADDR_CLEAR: regRdata <= clear_reg;
                `GCFC_ADDR_MODE: regRdata <= {4'h0, wake_reg, 1'b0};
                `GCFC_ADDR_PROG_DATA: regRdata <= progData_reg;
                `GCFC_ADDR_PROG_ADDR: regRdata <= progAddr_reg;
                default: regRdata <= 8'h00;
            endcase
        end
    end
endmodule

/* File: rtl/gcfc_defs.vh */
`ifndef GCFC_DEFS_VH
`define GCFC_DEFS_VH
// register addresses
`define GCFC_ADDR_TEMP_LOW 8'h60
`define GCFC_ADDR_TEMP_HIGH 8'h61
`define GCFC_ADDR_FLASH_CMD 8'h62
`define GCFC_ADDR_CLEAR 8'h63
`define GCFC_ADDR_MODE 8'h64
`define GCFC_ADDR_PROG_DATA 8'h6f
`define GCFC_ADDR_PROG_ADDR 8'h70
// clear register field positions
`define GCFC_BIT_DCR 0
`define GCFC_BIT_CCR 1
`define GCFC_BIT_SCR 2
`define GCFC_BIT_DTC 3
`define GCFC_BIT_CTC 4
`define GCFC_BIT_STAT 5
`define GCFC_BIT_POR 6
`define GCFC_BIT_RESERVED_TOP_BIT 7
// reset values
`define GCFC_CLEAR_RESET 8'h60
`define GCFC_WAKE_RESET 3'h7
// command codes
`define GCFC_CMD_PROGRAM 8'h0f
`define GCFC_CMD_ERASE0 8'h40
`define GCFC_CMD_ERASE1 8'h41
`define GCFC_CMD_ERASE2 8'h42
`define GCFC_CMD_ERASE_OFS 8'h43
`define GCFC_CMD_RAM2FL 8'h45
`define GCFC_CMD_FL2RAM 8'h48
`define GCFC_CMD_SLEEP 8'hf6
`define GCFC_CMD_CALSLEEP 8'hf7
// flash layout and calibration cycle limit
`define GCFC_FLASH_OFS_BASE 7'h60
`define GCFC_ERASED 8'hff
`define GCFC_LAST_PAGE_OFS 5'h1f
`define GCFC_CAL_CYCLES 8'h10
`endif

/* File: rtl/gcfc_sync.v */
`timescale 1ns/1ns
`include "gcfc_defs.vh"
module gcfc_sync (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // raw pin
    input wire pinIn,
    // filtered level and edge
    output reg pinLevel,
    output wire pinToggle
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    assign pinToggle = (s2_reg == s3_reg) && (s2_reg != pinLevel);
    always @(posedge clock) begin
        if (!rst_n) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            pinLevel <= 1'b1;
        end else begin
            s1_reg <= pinIn;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                pinLevel <= s2_reg;
            end
        end
    end
endmodule

/* File: verification/gcfc_assertions.sv */
`timescale 1ns/1ns
module gcfc_assertions (
    // clock and reset
    input wire clock,
    input wire rst_n,
    // register access
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire [7:0] regRdata,
    // pins and controls
    input wire [8:0] dieTemp,
    input wire linkPin,
    input wire statusOe,
    input wire [4:0] counterClear,
    input wire forceReset,
    input wire sleeping,
    input wire calibrating
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire clrWr = regWrite && regAddr == 8'h63;
    clear_pulse_a: assert property (clrWr |=> counterClear == $past(regWdata[4:0]))
        else $error("clear pulses differ from written bits");
    clear_idle_a: assert property (!clrWr |=> counterClear == 5'h00)
        else $error("clear pulse without a write");
    status_pin_a: assert property (clrWr |=> statusOe == !$past(regWdata[5]))
        else $error("status pin does not follow bit 5");
    reset_cause_a: assert property (forceReset |-> $past(clrWr) && $past(regWdata[7]))
        else $error("reset request without a write");
    reset_pulse_a: assert property (forceReset |=> !forceReset)
        else $error("reset request longer than one cycle");
    temp_low_a: assert property (regRead && regAddr == 8'h60 |=> regRdata == $past(dieTemp[7:0], 2))
        else $error("low temperature byte wrong");
    temp_high_a: assert property (regRead && regAddr == 8'h61 |=> regRdata == {7'h00, $past(dieTemp[8], 2)})
        else $error("high temperature byte wrong");
    link_wake_a: assert property (sleeping && linkPin != $past(linkPin) |-> ##[1:6] !sleeping)
        else $error("no wake on link toggle");
    cal_cancel_a: assert property (calibrating && linkPin != $past(linkPin) |=> !sleeping [*8])
        else $error("sleep after cancelled calibration");
endmodule
bind gcfc_core gcfc_assertions i_chk (.clock(clock), .rst_n(rst_n), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .dieTemp(dieTemp), .linkPin(linkPin), .statusOe(statusOe), .counterClear(counterClear),
    .forceReset(forceReset), .sleeping(sleeping), .calibrating(calibrating));

/* File: verification/gcfc_host.sv */
`timescale 1ns/1ns
module gcfc_host (
    // clock
    input wire clock,
    // register access
    output reg regWrite,
    output reg regRead,
    output reg [7:0] regAddr,
    output reg [7:0] regWdata,
    input wire [7:0] regRdata,
    // serial link pin
    output reg linkPin
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'h00;
        linkPin = 1'b1;
    end
    // released lines show the inverse of the last value
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clock);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clock);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
    endtask
    task rd(input [7:0] a, output [7:0] d);
        @(posedge clock);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clock);
        regRead <= 1'b0;
        regAddr <= ~a;
        @(posedge clock);
        #1 d = regRdata;
    endtask
    task toggle;
        @(posedge clock);
        linkPin <= ~linkPin;
    endtask
endmodule

/* File: verification/gauge_clear_and_flash_cmd_tb_top.sv */
`timescale 1ns/1ns
module gauge_clear_and_flash_cmd_tb_top;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg [8:0] dieTemp = 9'h12b;
    reg [2:0] senseLevel = 3'h0;
    reg calDone = 1'b0;
    wire regWrite, regRead, linkPin, statusOut, statusOe, forceReset, sleeping, calibrating;
    wire [7:0] regAddr, regWdata, regRdata;
    wire [4:0] counterClear;
    integer err_count = 0;
    integer checked = 0;
    integer i;
    reg [7:0] rv;
    reg [7:0] code;
    initial begin
        forever #25 clock = ~clock;
    end
    gcfc_host i_host (.clock(clock), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .linkPin(linkPin));
    gcfc_core i_dut (.clock(clock), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .dieTemp(dieTemp),
        .senseLevel(senseLevel), .calDone(calDone), .linkPin(linkPin), .statusOut(statusOut),
        .statusOe(statusOe), .counterClear(counterClear), .forceReset(forceReset),
        .sleeping(sleeping), .calibrating(calibrating));
    task results;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task check(input [7:0] seen, input [7:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task rchk(input [7:0] a, input [7:0] exp);
        i_host.rd(a, rv);
        check(rv, exp);
    endtask
    // bounded wait on sleeping (0) or calibrating (1)
    task waitSig(input integer which, input val);
        integer n;
        n = 0;
        while ((which ? calibrating : sleeping) !== val && n < 200) begin
            @(posedge clock);
            #1 n = n + 1;
        end
        check(n < 200, 1);
        if (n >= 200) results;
    endtask
    task waitCmd;
        integer n;
        n = 0;
        rv = 8'hff;
        while (rv !== 8'h00 && n < 60) begin
            i_host.rd(8'h62, rv);
            n = n + 1;
        end
        check(rv, 8'h00);
        if (n >= 60) results;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rchk(8'h63, 8'h60);
        check(statusOe, 8'h00);
        check(statusOut, 8'h00);
        rchk(8'h64, 8'h0e);
        i_host.wr(8'h61, 8'h00);
        rchk(8'h60, 8'h2b);
        rchk(8'h61, 8'h01);
        $display("test reset done");
        for (i = 0; i < 5; i = i + 1) begin
            i_host.wr(8'h63, 8'h60 | (8'h01 << i));
            #1 check(counterClear, 8'h01 << i);
            rchk(8'h63, 8'h60);
        end
        i_host.wr(8'h63, 8'h40);
        #1 check(statusOe, 1);
        rchk(8'h63, 8'h40);
        i_host.wr(8'h63, 8'h20);
        rchk(8'h63, 8'h20);
        check(statusOe, 0);
        i_host.wr(8'h63, 8'he0);
        #1 check(forceReset, 1);
        i_host.wr(8'h63, 8'h60);
        $display("test clear done");
        i_host.wr(8'h6f, 8'ha5);
        i_host.wr(8'h70, 8'h03);
        rchk(8'h6f, 8'ha5);
        rchk(8'h70, 8'h03);
        for (i = 0; i < 7; i = i + 1) begin
            code = 8'(56'h0f404142434548 >> (48 - 8 * i));
            i_host.wr(8'h62, code);
            if (code[6] && code != 8'h43) rchk(8'h62, code);
            waitCmd;
        end
        i_host.wr(8'h62, 8'h33);
        rchk(8'h62, 8'h00);
        $display("test flash done");
        i_host.wr(8'h62, 8'hf6);
        waitSig(0, 1);
        repeat (20) @(posedge clock);
        #1 check(sleeping, 1);
        i_host.toggle;
        waitSig(0, 0);
        senseLevel <= 3'h7;
        i_host.wr(8'h62, 8'hf6);
        repeat (20) @(posedge clock);
        #1 check(sleeping, 0);
        i_host.wr(8'h64, 8'h00);
        waitSig(0, 1);
        i_host.toggle;
        waitSig(0, 0);
        rchk(8'h62, 8'h00);
        i_host.wr(8'h64, 8'h0e);
        senseLevel <= 3'h0;
        $display("test sleep done");
        i_host.wr(8'h62, 8'hf7);
        waitSig(1, 1);
        @(posedge clock) calDone <= 1'b1;
        @(posedge clock) calDone <= 1'b0;
        waitSig(0, 1);
        i_host.toggle;
        waitSig(0, 0);
        i_host.wr(8'h62, 8'hf7);
        waitSig(1, 1);
        i_host.toggle;
        waitSig(1, 0);
        repeat (20) @(posedge clock);
        #1 check(sleeping, 0);
        $display("test calibrate done");
        results;
    end
endmodule
